// ===== hdl/eei_map.svh
// Constants for the serial memory target: address prefix, sizes and timing.
`ifndef EEI_MAP_SVH
`define EEI_MAP_SVH
`define EEI_DEV_PREFIX 4'ha
`define EEI_MEM_AW 12
`define EEI_PAGE_AW 5
`define EEI_ERASED_BYTE 8'hff
`define EEI_CLK_PERIOD_NS 10
`define EEI_PROG_TIME_NS 5000000
`define EEI_PROG_CYCLES (`EEI_PROG_TIME_NS / `EEI_CLK_PERIOD_NS)
`endif

// ===== hdl/eei_pkg.sv
// Types for the serial memory target.
package eei_pkg;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_DEVADR = 7'h02,
        ST_ADRHI = 7'h04,
        ST_ADRLO = 7'h08,
        ST_WDATA = 7'h10,
        ST_RDATA = 7'h20,
        ST_IGNORE = 7'h40
    } eei_state_e;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] data;
    } eei_wbyte_s;
endpackage : eei_pkg

// ===== hdl/eei_fifo.sv
// Small valid/ready FIFO with parameterised width and depth.
`timescale 1ns/1ps
module eei_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 4
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0] cnt_r;
    logic push;
    logic pop;
    assign in_ready_o = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem_r[rp_r];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : eei_fifo

// ===== hdl/eei_top.sv
// Two-wire serial memory target: bus front end, page buffer, program cycle and memory array.
`timescale 1ns/1ps
`include "eei_map.svh"

module eei_top #(
    parameter int MEM_AW = `EEI_MEM_AW,
    parameter int PAGE_AW = `EEI_PAGE_AW,
    parameter int PROG_CYCLES = `EEI_PROG_CYCLES,
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // Two-wire bus pins
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    // Straps and protection
    input wire logic STRAP_SELECT_BIT0_I,
    input wire logic STRAP_SELECT_BIT1_I,
    input wire logic STRAP_SELECT_BIT2_I,
    input wire logic WP_I,
    // Status
    output logic PROG_BUSY_O
);
    localparam int PAGE_N = 1 << PAGE_AW;
    localparam int MEM_N = 1 << MEM_AW;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] scl_s_r;
    logic [1:0] sda_s_r;
    logic [1:0] wp_s_r;
    logic [1:0] a0_s_r;
    logic [1:0] a1_s_r;
    logic [1:0] a2_s_r;
    logic scl_d_r;
    logic sda_d_r;
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            wp_s_r <= 2'h0;
            a0_s_r <= 2'h0;
            a1_s_r <= 2'h0;
            a2_s_r <= 2'h0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[0], SCL_I};
            sda_s_r <= {sda_s_r[0], SDA_I};
            wp_s_r <= {wp_s_r[0], WP_I};
            a0_s_r <= {a0_s_r[0], STRAP_SELECT_BIT0_I};
            a1_s_r <= {a1_s_r[0], STRAP_SELECT_BIT1_I};
            a2_s_r <= {a2_s_r[0], STRAP_SELECT_BIT2_I};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end

    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    assign scl = scl_s_r[1];
    assign sda = sda_s_r[1];
    assign scl_rise = scl & ~scl_d_r;
    assign scl_fall = ~scl & scl_d_r;
    assign start_ev = scl & scl_d_r & sda_d_r & ~sda;
    assign stop_ev = scl & scl_d_r & ~sda_d_r & sda;

    ////////////////////////////////////////////////////////////////////////////////
    // Memory array, erased at power-up
    logic [7:0] mem_r [MEM_N];
    logic [7:0] page_r [PAGE_N];
    logic [PAGE_N-1:0] page_vld_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Byte framing
    eei_pkg::eei_state_e state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic ack_phase_r;
    logic ack_ok_r;
    logic rd_nack_r;
    logic [MEM_AW-1:0] addr_r;
    logic [7:0] adr_hi_r;
    logic wr_pend_r;
    logic wp_latched_r;
    logic sda_out_r;
    logic sda_oe_r;
    logic prog_busy_r;
    logic [$clog2(PROG_CYCLES+1)-1:0] prog_cnt_r;
    logic commit_go_r;
    logic [PAGE_AW:0] commit_idx_r;
    logic [MEM_AW-PAGE_AW-1:0] page_base_r;

    logic byte_done;
    logic [7:0] rx_byte;
    logic addr_match;
    assign byte_done = scl_rise & ~ack_phase_r & (bit_cnt_r == 4'h7);
    assign rx_byte = {shift_r[6:0], sda};
    logic [MEM_AW-1:0] adr_join;
    assign adr_join = MEM_AW'({adr_hi_r, rx_byte});
    assign addr_match = (rx_byte[7:4] == `EEI_DEV_PREFIX)
        & (rx_byte[3:1] == {a2_s_r[1], a1_s_r[1], a0_s_r[1]});

    // Next byte to send: freshly read from the array at the current address
    logic [7:0] rd_byte;
    assign rd_byte = mem_r[addr_r];

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            state_r <= eei_pkg::ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            ack_phase_r <= 1'b0;
            ack_ok_r <= 1'b0;
            rd_nack_r <= 1'b0;
            addr_r <= '0;
            adr_hi_r <= 8'h00;
            wr_pend_r <= 1'b0;
            wp_latched_r <= 1'b0;
            sda_out_r <= 1'b1;
            sda_oe_r <= 1'b0;
            page_vld_r <= '0;
            page_base_r <= '0;
            commit_go_r <= 1'b0;
        end else begin
            commit_go_r <= 1'b0;
            if (stop_ev) begin
                state_r <= eei_pkg::ST_IDLE;
                sda_oe_r <= 1'b0;
                ack_phase_r <= 1'b0;
                if (wr_pend_r && !prog_busy_r) begin
                    commit_go_r <= 1'b1;
                end
                wr_pend_r <= 1'b0;
            end else if (start_ev) begin
                state_r <= eei_pkg::ST_DEVADR;
                bit_cnt_r <= 4'h0;
                ack_phase_r <= 1'b0;
                sda_oe_r <= 1'b0;
                if (wr_pend_r) begin
                    page_vld_r <= '0;
                end
                wr_pend_r <= 1'b0;
            end else if (state_r != eei_pkg::ST_IDLE && state_r != eei_pkg::ST_IGNORE) begin
                if (byte_done) begin
                    shift_r <= rx_byte;
                    ack_phase_r <= 1'b1;
                    bit_cnt_r <= 4'h0;
                    ack_ok_r <= 1'b0;
                    unique case (state_r)
                        eei_pkg::ST_DEVADR: begin
                            ack_ok_r <= addr_match & ~prog_busy_r;
                        end
                        eei_pkg::ST_ADRHI: begin
                            adr_hi_r <= rx_byte;
                            ack_ok_r <= 1'b1;
                        end
                        eei_pkg::ST_ADRLO: begin
                            addr_r <= adr_join;
                            page_base_r <= adr_join[MEM_AW-1:PAGE_AW];
                            ack_ok_r <= 1'b1;
                        end
                        eei_pkg::ST_WDATA: begin
                            ack_ok_r <= ~wp_latched_r;
                            if (!wp_latched_r) begin
                                page_r[addr_r[PAGE_AW-1:0]] <= rx_byte;
                                page_vld_r[addr_r[PAGE_AW-1:0]] <= 1'b1;
                                addr_r[PAGE_AW-1:0] <= addr_r[PAGE_AW-1:0] + 1'b1;
                                wr_pend_r <= 1'b1;
                            end
                        end
                        eei_pkg::ST_RDATA: begin
                            rd_nack_r <= 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end else if (!ack_phase_r && scl_rise) begin
                    // Outgoing read bits live in shift_r, so only received bytes shift here
                    if (state_r != eei_pkg::ST_RDATA) begin
                        shift_r <= rx_byte;
                    end
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end else if (ack_phase_r && scl_rise) begin
                    // Controller's answer to a sent byte is taken on the ninth rise
                    if (state_r == eei_pkg::ST_RDATA) begin
                        rd_nack_r <= sda;
                    end
                end else if (ack_phase_r && scl_fall && bit_cnt_r == 4'h0) begin
                    // Falling edge ending the eighth bit: drive the acknowledge
                    bit_cnt_r <= 4'h1;
                    if (state_r != eei_pkg::ST_RDATA) begin
                        sda_oe_r <= ack_ok_r;
                        sda_out_r <= 1'b0;
                    end else begin
                        sda_oe_r <= 1'b0;
                    end
                    if (state_r == eei_pkg::ST_ADRLO) begin
                        wp_latched_r <= wp_s_r[1];
                    end
                end else if (ack_phase_r && scl_fall) begin
                    // End of the ninth clock: pick the next phase
                    ack_phase_r <= 1'b0;
                    bit_cnt_r <= 4'h0;
                    sda_oe_r <= 1'b0;
                    unique case (state_r)
                        eei_pkg::ST_DEVADR: begin
                            if (!ack_ok_r) begin
                                state_r <= eei_pkg::ST_IGNORE;
                            end else if (shift_r[0]) begin
                                state_r <= eei_pkg::ST_RDATA;
                                sda_oe_r <= ~rd_byte[7];
                                sda_out_r <= 1'b0;
                                shift_r <= {rd_byte[6:0], 1'b1};
                                addr_r <= addr_r + 1'b1;
                            end else begin
                                state_r <= eei_pkg::ST_ADRHI;
                            end
                        end
                        eei_pkg::ST_ADRHI: state_r <= eei_pkg::ST_ADRLO;
                        eei_pkg::ST_ADRLO: begin
                            // Write protect taken on this edge, before the first data bit
                            wp_latched_r <= wp_s_r[1];
                            state_r <= eei_pkg::ST_WDATA;
                        end
                        eei_pkg::ST_WDATA: begin
                            if (!ack_ok_r) begin
                                state_r <= eei_pkg::ST_IGNORE;
                                page_vld_r <= '0;
                                wr_pend_r <= 1'b0;
                            end
                        end
                        eei_pkg::ST_RDATA: begin
                            if (rd_nack_r) begin
                                state_r <= eei_pkg::ST_IGNORE;
                            end else begin
                                sda_oe_r <= ~rd_byte[7];
                                sda_out_r <= 1'b0;
                                shift_r <= {rd_byte[6:0], 1'b1};
                                addr_r <= addr_r + 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end else if (state_r == eei_pkg::ST_RDATA && scl_fall && !ack_phase_r) begin
                    // Shift the next outgoing bit after the falling edge
                    sda_oe_r <= ~shift_r[7];
                    shift_r <= {shift_r[6:0], 1'b1};
                end
            end
            // Page fully handed to the FIFO: forget it so the next session starts clean
            if (commit_idx_r[PAGE_AW] && prog_busy_r) begin
                page_vld_r <= '0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Program cycle: stream the valid page bytes through the FIFO into the array
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    eei_pkg::eei_wbyte_s fifo_in;
    eei_pkg::eei_wbyte_s fifo_out;
    logic [PAGE_AW-1:0] cidx;
    assign cidx = commit_idx_r[PAGE_AW-1:0];
    assign fifo_in_valid = prog_busy_r & ~commit_idx_r[PAGE_AW] & page_vld_r[cidx];
    assign fifo_in.addr = MEM_AW'({page_base_r, cidx});
    assign fifo_in.data = page_r[cidx];

    eei_fifo #(
        .WIDTH($bits(eei_pkg::eei_wbyte_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(CLK_I),
        .rstn_i(RSTN_I),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_in),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(prog_busy_r),
        .out_data_o(fifo_out)
    );

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) begin
            prog_busy_r <= 1'b0;
            prog_cnt_r <= '0;
            commit_idx_r <= '0;
        end else if (commit_go_r) begin
            prog_busy_r <= 1'b1;
            prog_cnt_r <= '0;
            commit_idx_r <= '0;
        end else if (prog_busy_r) begin
            if (!commit_idx_r[PAGE_AW] && (!page_vld_r[cidx] || fifo_in_ready)) begin
                commit_idx_r <= commit_idx_r + 1'b1;
            end
            // Busy for the full program time, then release the bus
            if (prog_cnt_r == ($bits(prog_cnt_r))'(PROG_CYCLES - 1)) begin
                prog_busy_r <= 1'b0;
            end else begin
                prog_cnt_r <= prog_cnt_r + 1'b1;
            end
        end
    end

    // Array writes; page length is far shorter than the program time, so all land in time
    // Plain always since the erased contents are preset by an initial block
    always @(posedge CLK_I) begin
        if (fifo_out_valid && prog_busy_r) begin
            mem_r[fifo_out.addr] <= fifo_out.data;
        end
    end

    // Erased delivery state
    initial begin
        for (int i = 0; i < MEM_N; i++) begin
            mem_r[i] = `EEI_ERASED_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin outputs
    assign SDA_O = sda_out_r;
    assign SDA_OE_O = sda_oe_r;
    assign PROG_BUSY_O = prog_busy_r;
endmodule : eei_top

// ===== verif/eei_ctrl_model.sv
// Bus controller model: frames, bytes and acknowledge handling on the two-wire bus.
`timescale 1ns/1ps
module eei_ctrl_model #(
    parameter int QTR = 10
) (
    // Clock and bus
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // SCL idles high between frames; a released SDA floats to the pull-up
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic qwait();
        repeat (QTR) @(negedge clk_i);
    endtask : qwait

    // Each SCL half lasts two quarters, enough for the target's synchronisers
    task automatic put_bit(input logic b, output logic seen);
        sda_low_o = !b;
        qwait();
        scl_o = 1'b1;
        qwait();
        seen = sda_i;
        qwait();
        scl_o = 1'b0;
        qwait();
    endtask : put_bit

    task automatic bus_start();
        sda_low_o = 1'b0;
        qwait();
        scl_o = 1'b1;
        qwait();
        sda_low_o = 1'b1;
        qwait();
        scl_o = 1'b0;
        qwait();
    endtask : bus_start

    task automatic bus_stop();
        sda_low_o = 1'b1;
        qwait();
        scl_o = 1'b1;
        qwait();
        sda_low_o = 1'b0;
        qwait();
    endtask : bus_stop

    task automatic put_byte(input logic [7:0] d, output logic nack);
        logic x;
        for (int i = 7; i >= 0; i--) put_bit(d[i], x);
        put_bit(1'b1, nack);
    endtask : put_byte

    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic x;
        for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
        put_bit(!ack, x);
    endtask : get_byte
endmodule : eei_ctrl_model

// ===== verif/eei_top_monitor.sv
// Concurrent checks on the serial memory target ports.
`timescale 1ns/1ps
module eei_top_monitor #(
    parameter int PROG_CYCLES = 200
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RSTN_I,
    // Bus and status
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire logic SDA_OE_O,
    input wire logic PROG_BUSY_O
);
    logic sda_q_r;
    logic framed_r;
    logic [7:0] since_stop_r;
    int busy_cnt_r;
    wire logic stop_w = SCL_I && !sda_q_r && SDA_I;
    wire logic start_w = SCL_I && sda_q_r && !SDA_I;

    always_ff @(posedge CLK_I) sda_q_r <= SDA_I;

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I || stop_w) framed_r <= 1'b0;
        else if (start_w) framed_r <= 1'b1;
    end

    // Saturates so a long idle bus cannot wrap back into the window
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I) since_stop_r <= 8'hff;
        else if (stop_w) since_stop_r <= 8'h0;
        else if (since_stop_r != 8'hff) since_stop_r <= since_stop_r + 8'h1;
    end

    always_ff @(posedge CLK_I) begin
        if (!RSTN_I || !PROG_BUSY_O) busy_cnt_r <= 0;
        else busy_cnt_r <= busy_cnt_r + 1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    rst_idle_a: assert property (disable iff (1'b0) !RSTN_I |=> !SDA_OE_O && !PROG_BUSY_O)
        else $error("outputs not idle after reset");
    oe_busy_a: assert property (PROG_BUSY_O |-> !SDA_OE_O)
        else $error("target drives while programming");
    oe_framed_a: assert property (SDA_OE_O |-> framed_r)
        else $error("target drives outside a frame");
    oe_scl_low_a: assert property ($changed(SDA_OE_O) |-> !SCL_I)
        else $error("data output changed while clock high");
    oe_setup_a: assert property ($rose(SDA_OE_O) |-> !SCL_I [*6])
        else $error("drive started too close to clock rise");
    busy_stop_a: assert property ($rose(PROG_BUSY_O) |-> since_stop_r <= 8'd12)
        else $error("program cycle without a preceding stop");
    busy_len_a: assert property ($fell(PROG_BUSY_O) |->
        busy_cnt_r >= PROG_CYCLES - 1 && busy_cnt_r <= PROG_CYCLES + 1)
        else $error("program cycle length wrong");
    busy_hold_a: assert property ($rose(PROG_BUSY_O) |-> PROG_BUSY_O [*8])
        else $error("program cycle broken up");

    cover property ($rose(PROG_BUSY_O));
    cover property ($fell(PROG_BUSY_O));
    cover property ($rose(SDA_OE_O) && framed_r);
endmodule : eei_top_monitor

bind eei_top eei_top_monitor #(.PROG_CYCLES(PROG_CYCLES)) i_eei_top_monitor (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
    .SDA_OE_O(SDA_OE_O), .PROG_BUSY_O(PROG_BUSY_O)
);

// ===== verif/tb.sv
// Self-checking bench: a bus controller model drives the serial memory target.
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [7:0] dev;
        logic nack;
    } eei_row_s;
    localparam logic [7:0] DEV_W = 8'haa;
    localparam logic [7:0] DEV_R = 8'hab;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wp = 1'b0;
    logic [2:0] strap = 3'h5;
    logic scl;
    logic sda_low;
    logic sda_o;
    logic sda_oe;
    logic busy;
    logic busy_q = 1'b0;
    logic nack;
    logic [7:0] rd;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    int rises = 0;
    int r0;
    eei_row_s rows [6] = '{'{8'hab, 1'b0}, '{8'hba, 1'b1}, '{8'ha9, 1'b1}, '{8'ha2, 1'b1}, '{8'hae, 1'b1},
        '{8'haa, 1'b0}};
    wire logic sda = !(sda_low || (sda_oe && !sda_o));

    eei_top #(.PROG_CYCLES(1000)) i_eei_top (
        .CLK_I(clk), .RSTN_I(rstn), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
        .STRAP_SELECT_BIT0_I(strap[0]), .STRAP_SELECT_BIT1_I(strap[1]), .STRAP_SELECT_BIT2_I(strap[2]),
        .WP_I(wp), .PROG_BUSY_O(busy)
    );
    eei_ctrl_model i_eei_ctrl_model (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

    initial begin
        forever #5 clk = ~clk;
    end

    // Ceiling sits well above the roughly 45k cycles the sequence needs
    always @(posedge clk) begin
        busy_q <= busy;
        if (busy && !busy_q) rises++;
        cycles++;
        if (cycles == 80000) begin
            error_cnt++;
            $display("FAIL timeout expected finish seen hang");
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", nm, exp, got);
            error_cnt++;
        end
    endtask : chk

    task automatic send(input logic [7:0] b, input logic exp_nack, input string nm);
        i_eei_ctrl_model.put_byte(b, nack);
        chk(nm, {7'h0, exp_nack}, {7'h0, nack});
    endtask : send

    task automatic seek(input logic [7:0] hi, input logic [7:0] lo);
        i_eei_ctrl_model.bus_start();
        send(DEV_W, 1'b0, "write select");
        send(hi, 1'b0, "addr hi ack");
        send(lo, 1'b0, "addr lo ack");
    endtask : seek

    task automatic rd_at(input logic [7:0] hi, input logic [7:0] lo);
        seek(hi, lo);
        i_eei_ctrl_model.bus_start();
        send(DEV_R, 1'b0, "read select");
    endtask : rd_at

    task automatic get(input logic last, input logic [7:0] exp, input string nm);
        i_eei_ctrl_model.get_byte(!last, rd);
        chk(nm, exp, rd);
    endtask : get

    // Reads one byte once acknowledged, so polling never launches a write
    task automatic poll();
        int n;
        n = 0;
        nack = 1'b1;
        while (nack && n < 20) begin
            i_eei_ctrl_model.bus_start();
            i_eei_ctrl_model.put_byte(DEV_R, nack);
            if (!nack) i_eei_ctrl_model.get_byte(1'b0, rd);
            i_eei_ctrl_model.bus_stop();
            n++;
        end
        chk("poll ack", 8'h0, {7'h0, nack});
    endtask : poll

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(negedge clk);
        chk("oe in reset", 8'h0, {7'h0, sda_oe});
        chk("busy in reset", 8'h0, {7'h0, busy});
        rstn = 1'b1;
        foreach (rows[k]) begin
            i_eei_ctrl_model.bus_start();
            send(rows[k].dev, rows[k].nack, "dev select");
            if (!nack && rows[k].dev[0]) get(1'b1, 8'hff, "erased read");
            i_eei_ctrl_model.bus_stop();
        end
        poll();
        seek(8'h01, 8'h23);
        send(8'h5a, 1'b0, "data ack");
        i_eei_ctrl_model.bus_stop();
        chk("busy after stop", 8'h1, {7'h0, busy});
        i_eei_ctrl_model.bus_start();
        send(DEV_R, 1'b1, "busy refuses");
        i_eei_ctrl_model.bus_stop();
        poll();
        rd_at(8'h01, 8'h23);
        get(1'b0, 8'h5a, "selected read");
        get(1'b1, 8'hff, "next byte");
        i_eei_ctrl_model.bus_stop();
        r0 = rises;
        seek(8'h00, 8'h1e);
        for (int i = 0; i < 34; i++) send(8'h40 + 8'(i), 1'b0, "page ack");
        i_eei_ctrl_model.bus_stop();
        poll();
        chk("one program cycle", 8'h1, 8'(rises - r0));
        rd_at(8'h00, 8'h00);
        for (int k = 0; k < 33; k++) get(k == 32, k < 32 ? 8'h42 + 8'(k) : 8'hff, "page data");
        i_eei_ctrl_model.bus_stop();
        wp = 1'b1;
        seek(8'h01, 8'h23);
        send(8'h11, 1'b1, "protected data");
        i_eei_ctrl_model.bus_stop();
        wp = 1'b0;
        chk("no program cycle", 8'h0, {7'h0, busy});
        rd_at(8'h01, 8'h23);
        get(1'b1, 8'h5a, "kept data");
        i_eei_ctrl_model.bus_stop();
        seek(8'h0f, 8'hff);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        chk("oe after reset", 8'h0, {7'h0, sda_oe});
        rstn = 1'b1;
        i_eei_ctrl_model.bus_stop();
        rd_at(8'hff, 8'hff);
        get(1'b0, 8'hff, "last location");
        get(1'b1, 8'h42, "wrapped read");
        i_eei_ctrl_model.bus_stop();
        wrap_up();
    end
endmodule : tb
